// *** rtcal_ccr_ctrl.sv ***
// Clock/control space write protection, alarms, nonvolatile timing and battery switchover.
`timescale 1ns/1ps
`include "rtcal_defs.svh"
module rtcal_ccr_ctrl
  import rtcal_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = `RTCAL_NV_WRITE_MS * `RTCAL_CLK_KHZ
)
(
  // Clock and reset.
  input  wire logic       core_clk_in,
  input  wire logic       resetn_in,
  // Register port, fed by the serial bus front end.
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Transfer framing from the front end.
  input  wire logic       xfer_stop_in,
  input  wire logic       xfer_abort_in,
  // Supply comparators, asynchronous.
  input  wire logic       cmp_below_bat_in,
  input  wire logic       cmp_above_bat_in,
  input  wire logic       cmp_below_trip_in,
  input  wire logic       cmp_above_trip_in,
  // Status towards the chip.
  output logic            on_battery_out,
  output logic            bus_enabled_out,
  output logic            alarm_irq_out,
  output logic            nv_busy_out
);
  localparam int CW = $clog2(NV_WRITE_CYCLES + 1);
  localparam logic [CW-1:0] NV_LAST = CW'(NV_WRITE_CYCLES - 1);

  logic [7:0]      alarm_mem [`RTCAL_ALM_COUNT];
  logic [7:0]      ctrl_mem  [`RTCAL_CTRL_COUNT];
  logic [7:0]      rtc_mem   [`RTCAL_RTC_COUNT];
  logic            write_enable_latch;
  logic            register_write_enable_latch;
  logic            alarm_zero_flag;
  logic            alarm_one_flag;
  logic            wrote_any;
  logic            wrote_ctrl;
  logic [7:0]      last_addr;
  rtcal_nv_state_t nv_state;
  logic [CW-1:0]   nv_count;
  logic [3:0]      cmp_meta;
  logic [3:0]      cmp_sync;
  logic [1:0]      match_q;
  logic [1:0]      match;
  logic            wr;
  logic            rd;
  logic            stop;
  logic            abort;
  rtcal_region_t   wr_region;
  logic            unlocked;
  logic            data_wr;
  logic            stat_wr;
  logic            stat_rd;
  logic            alarm_commit;
  logic            nv_start;
  logic            fo_en;
  logic            im;
  logic            alarm_zero_arm;
  logic            alarm_one_arm;
  logic            fire0;
  logic            fire1;

  function automatic rtcal_region_t region(input logic [7:0] a);
    if (a <= `RTCAL_ALM_LAST)
      region = (a[2:0] == `RTCAL_ALM_GAP) ? RTCAL_RG_NONE : RTCAL_RG_ALARM;
    else if (a >= `RTCAL_CTRL_BASE && a <= `RTCAL_CTRL_LAST)
      region = RTCAL_RG_CTRL;
    else if (a >= `RTCAL_RTC_BASE && a <= `RTCAL_RTC_LAST)
      region = RTCAL_RG_RTC;
    else if (a == `RTCAL_STAT_ADDR)
      region = RTCAL_RG_STAT;
    else
      region = RTCAL_RG_NONE;
  endfunction

  // A bus that is switched off on battery sees neither strobes nor framing.
  assign wr    = reg_wr_in & bus_enabled_out;
  assign rd    = reg_rd_in & bus_enabled_out;
  assign stop  = xfer_stop_in & bus_enabled_out;
  assign abort = xfer_abort_in & bus_enabled_out;
  assign wr_region = region(reg_addr_in);

  // Programming in progress also locks the space so a commit cannot be torn.
  assign unlocked = write_enable_latch & register_write_enable_latch
                  & (nv_state == RTCAL_NV_IDLE);
  assign stat_wr  = wr & (wr_region == RTCAL_RG_STAT);
  assign stat_rd  = rd & (region(reg_addr_in) == RTCAL_RG_STAT);
  assign data_wr  = wr & unlocked
                  & (wr_region != RTCAL_RG_STAT) & (wr_region != RTCAL_RG_NONE);

  assign fo_en          = |ctrl_mem[`RTCAL_INT_IDX][`RTCAL_FO_HI:`RTCAL_FO_LO];
  assign im             = ctrl_mem[`RTCAL_INT_IDX][`RTCAL_BIT_IM];
  assign alarm_zero_arm = ctrl_mem[`RTCAL_INT_IDX][`RTCAL_BIT_ALARM_ZERO_ARM];
  assign alarm_one_arm  = ctrl_mem[`RTCAL_INT_IDX][`RTCAL_BIT_ALARM_ONE_ARM];

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      write_enable_latch          <= 1'b0;
      register_write_enable_latch <= 1'b0;
    end
    else if (stat_wr)
    begin
      if (reg_wdata_in == `RTCAL_STAT_CLR)
      begin
        write_enable_latch          <= 1'b0;
        register_write_enable_latch <= 1'b0;
      end
      else if (reg_wdata_in == `RTCAL_STAT_WEL)
        write_enable_latch <= 1'b1;
      else if (reg_wdata_in == `RTCAL_STAT_REGISTER_WRITE_ENABLE_LATCH && write_enable_latch)
        register_write_enable_latch <= 1'b1;
    end
    else if (stop && wrote_any)
      register_write_enable_latch <= 1'b0;
  end

  // Per-transfer record of what was written; an abort drops it but leaves the latches.
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wrote_any  <= 1'b0;
      wrote_ctrl <= 1'b0;
      last_addr  <= `RTCAL_ZERO_BYTE;
    end
    else if (stop || abort)
    begin
      wrote_any  <= 1'b0;
      wrote_ctrl <= 1'b0;
    end
    else if (data_wr)
    begin
      wrote_any  <= 1'b1;
      wrote_ctrl <= wrote_ctrl | (wr_region == RTCAL_RG_CTRL);
      last_addr  <= reg_addr_in;
    end
  end

  // Weekday and century alarm bytes end above the low five and never commit.
  assign alarm_commit = (last_addr <= `RTCAL_ALM_LAST)
                      & (last_addr[2:0] <= `RTCAL_ALM_COMMIT);
  assign nv_start = stop & wrote_any & (wrote_ctrl | alarm_commit);

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      nv_state <= RTCAL_NV_IDLE;
      nv_count <= '0;
    end
    else
    begin
      unique case (nv_state)
        RTCAL_NV_IDLE:
        begin
          nv_count <= '0;
          if (nv_start)
            nv_state <= RTCAL_NV_BUSY;
        end
        RTCAL_NV_BUSY:
        begin
          nv_count <= nv_count + CW'(1);
          if (nv_count == NV_LAST)
            nv_state <= RTCAL_NV_IDLE;
        end
        default:
          nv_state <= RTCAL_NV_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      nv_busy_out <= 1'b0;
    else
      nv_busy_out <= (nv_state == RTCAL_NV_BUSY) ? (nv_count != NV_LAST) : nv_start;
  end

  // Storage; the alarm page is indexed by the low nibble, which spans exactly its sixteen addresses 0x00 to 0x0F.
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      for (int i = 0; i < `RTCAL_ALM_COUNT; i++)
        alarm_mem[i] <= `RTCAL_ZERO_BYTE;
    end
    else if (data_wr && wr_region == RTCAL_RG_ALARM)
      alarm_mem[reg_addr_in[3:0]] <= reg_wdata_in;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      for (int i = 0; i < `RTCAL_CTRL_COUNT; i++)
        ctrl_mem[i] <= (i == `RTCAL_PWR_IDX) ? `RTCAL_PWR_RESET : `RTCAL_ZERO_BYTE;
    end
    else if (data_wr && wr_region == RTCAL_RG_CTRL)
      ctrl_mem[reg_addr_in[2:0]] <= reg_wdata_in;
  end

  // Clock bytes are volatile and take effect at once.
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      for (int i = 0; i < `RTCAL_RTC_COUNT; i++)
        rtc_mem[i] <= `RTCAL_ZERO_BYTE;
    end
    else if (data_wr && wr_region == RTCAL_RG_RTC)
      rtc_mem[reg_addr_in[2:0]] <= reg_wdata_in;
  end

  // An alarm with no field enabled never matches.
  for (genvar k = 0; k < 2; k++)
  begin : g_alarm
    always_comb
    begin
      logic any;
      logic ok;
      any = 1'b0;
      ok  = 1'b1;
      for (int f = 0; f < `RTCAL_RTC_COUNT; f++)
      begin
        if (f != `RTCAL_ALM_GAP && alarm_mem[k*8+f][`RTCAL_BIT_ENABLE])
        begin
          any = 1'b1;
          ok  = ok & (alarm_mem[k*8+f][6:0] == rtc_mem[f][6:0]);
        end
      end
      match[k] = any & ok;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      match_q <= 2'h0;
    else
      match_q <= match;
  end

  // Fire on the start of each match so one match sets a flag only once.
  assign fire0 = match[0] & ~match_q[0] & alarm_zero_arm & ~fo_en;
  assign fire1 = match[1] & ~match_q[1] & alarm_one_arm & ~fo_en
               & ~(im & alarm_zero_arm);

  // The read strobe stands for the eighth bus clock; an event in that cycle wins.
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      alarm_zero_flag <= 1'b0;
      alarm_one_flag  <= 1'b0;
    end
    else
    begin
      alarm_zero_flag <= fire0 | (alarm_zero_flag & ~stat_rd);
      alarm_one_flag  <= fire1 | (alarm_one_flag & ~stat_rd);
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      alarm_irq_out <= 1'b0;
    else
      alarm_irq_out <= fire0 | fire1;
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cmp_meta <= 4'h0;
      cmp_sync <= 4'h0;
    end
    else
    begin
      cmp_meta <= {cmp_above_trip_in, cmp_below_trip_in, cmp_above_bat_in, cmp_below_bat_in};
      cmp_sync <= cmp_meta;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      on_battery_out <= 1'b0;
    else if (!ctrl_mem[`RTCAL_PWR_IDX][`RTCAL_BIT_BSW])
    begin
      if (!on_battery_out && cmp_sync[0] && cmp_sync[2])
        on_battery_out <= 1'b1;
      else if (on_battery_out && (cmp_sync[1] || cmp_sync[3]))
        on_battery_out <= 1'b0;
    end
    else
    begin
      if (!on_battery_out && cmp_sync[0])
        on_battery_out <= 1'b1;
      else if (on_battery_out && cmp_sync[1])
        on_battery_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      bus_enabled_out <= 1'b1;
    else
      bus_enabled_out <= ~(on_battery_out & ctrl_mem[`RTCAL_PWR_IDX][`RTCAL_BIT_BUS_OFF_ON_BATTERY]);
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      reg_rdata_out <= `RTCAL_ZERO_BYTE;
    else if (!rd)
      reg_rdata_out <= `RTCAL_ZERO_BYTE;
    else
    begin
      unique case (region(reg_addr_in))
        RTCAL_RG_ALARM: reg_rdata_out <= alarm_mem[reg_addr_in[3:0]];
        RTCAL_RG_CTRL:  reg_rdata_out <= ctrl_mem[reg_addr_in[2:0]];
        RTCAL_RG_RTC:   reg_rdata_out <= rtc_mem[reg_addr_in[2:0]];
        RTCAL_RG_STAT:  reg_rdata_out <= {on_battery_out, alarm_one_flag, alarm_zero_flag,
                                          2'h0, register_write_enable_latch,
                                          write_enable_latch, 1'b0};
        RTCAL_RG_NONE:  reg_rdata_out <= `RTCAL_ZERO_BYTE;
      endcase
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence nv_begin_s;
    nv_start && nv_state == RTCAL_NV_IDLE;
  endsequence
  sequence nv_hold_s;
    nv_busy_out [*8];
  endsequence

  latch_clear_a: assert property (stat_wr && reg_wdata_in == `RTCAL_STAT_CLR
    |=> !write_enable_latch && !register_write_enable_latch)
    else $error("Zero status write left a latch set.");
  register_write_enable_latch_drop_a: assert property (stop && wrote_any && !stat_wr
    |=> !register_write_enable_latch)
    else $error("Register latch survived a completed write.");
  abort_keep_a: assert property (abort && register_write_enable_latch && !stat_wr
    |=> register_write_enable_latch)
    else $error("Abort cleared the register latch.");
  read_keep_a: assert property (rd && !wr && !stop
    |=> $stable(write_enable_latch) && $stable(register_write_enable_latch))
    else $error("Read changed a latch.");
  locked_pwr_a: assert property (wr && !unlocked && !stat_wr
    |=> $stable(ctrl_mem[`RTCAL_PWR_IDX]) && $stable(ctrl_mem[`RTCAL_INT_IDX]))
    else $error("Locked write changed a control byte.");
  flag_clear_a: assert property (stat_rd && !fire0 |=> !alarm_zero_flag)
    else $error("Status read did not clear alarm flag.");
  single_set_a: assert property (fire0 |=> alarm_zero_flag && alarm_irq_out)
    else $error("Alarm match did not set flag and pulse.");
  pulse_only0_a: assert property (im && alarm_zero_arm && !fire0
    |=> !alarm_irq_out)
    else $error("Alarm one fired in repeat mode with both armed.");
  fo_block_a: assert property (fo_en |=> !alarm_irq_out && !$rose(alarm_one_flag))
    else $error("Alarm fired with frequency output on.");
  nv_run_a: assert property (nv_begin_s |=> nv_hold_s)
    else $error("Programming cycle ended early.");
  alm_nocommit_a: assert property (stop && wrote_any && !wrote_ctrl
    && last_addr[2:0] > `RTCAL_ALM_COMMIT && nv_state == RTCAL_NV_IDLE |=> !nv_busy_out)
    else $error("Alarm write ending high started programming.");
  std_switch_a: assert property (!ctrl_mem[`RTCAL_PWR_IDX][`RTCAL_BIT_BSW]
    && !on_battery_out && cmp_sync[0] && !cmp_sync[2] |=> !on_battery_out)
    else $error("Standard mode switched with one condition.");
  bus_off_a: assert property (!bus_enabled_out |=> reg_rdata_out == `RTCAL_ZERO_BYTE)
    else $error("Bus answered while switched off.");
endmodule

// *** rtcal_defs.svh ***
// Address map, field positions, reset values and timing of the clock/control block.
`ifndef RTCAL_DEFS_SVH
`define RTCAL_DEFS_SVH
`define RTCAL_ALM_LAST     8'h0F
`define RTCAL_ALM_GAP      3'h5
`define RTCAL_ALM_COMMIT   3'h4
`define RTCAL_ALM_COUNT    16
`define RTCAL_CTRL_BASE    8'h10
`define RTCAL_CTRL_LAST    8'h14
`define RTCAL_CTRL_COUNT   5
`define RTCAL_INT_IDX      3'h1
`define RTCAL_PWR_IDX      3'h4
`define RTCAL_RTC_BASE     8'h30
`define RTCAL_RTC_LAST     8'h37
`define RTCAL_RTC_COUNT    8
`define RTCAL_STAT_ADDR    8'h3F
`define RTCAL_STAT_CLR     8'h00
`define RTCAL_STAT_WEL     8'h02
`define RTCAL_STAT_REGISTER_WRITE_ENABLE_LATCH    8'h06
`define RTCAL_BIT_ENABLE   7
`define RTCAL_BIT_IM       7
`define RTCAL_BIT_ALARM_ONE_ARM     6
`define RTCAL_BIT_ALARM_ZERO_ARM     5
`define RTCAL_FO_HI        1
`define RTCAL_FO_LO        0
`define RTCAL_BIT_BUS_OFF_ON_BATTERY     7
`define RTCAL_BIT_BSW      6
`define RTCAL_PWR_RESET    8'h40
`define RTCAL_ZERO_BYTE    8'h00
`define RTCAL_NV_WRITE_MS  20
`define RTCAL_CLK_KHZ      50000
`endif

// *** rtcal_pkg.sv ***
// Types shared by the clock/control block.
package rtcal_pkg;
  typedef enum logic [1:0] {
    RTCAL_NV_IDLE = 2'b01,
    RTCAL_NV_BUSY = 2'b10
  } rtcal_nv_state_t;
  typedef enum logic [4:0] {
    RTCAL_RG_ALARM = 5'b00001,
    RTCAL_RG_CTRL  = 5'b00010,
    RTCAL_RG_RTC   = 5'b00100,
    RTCAL_RG_STAT  = 5'b01000,
    RTCAL_RG_NONE  = 5'b10000
  } rtcal_region_t;
endpackage

// *** rtcal_host_model.sv ***
// Host-side model of the register port: byte writes, reads and transfer framing.
`timescale 1ns/1ps
module rtcal_host_model
(
  // Clock.
  input  wire logic       clk_in,
  // Register port towards the block.
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out,
  // Transfer framing.
  output logic            stop_out,
  output logic            abort_out
);
  initial
  begin
    addr_out  = 8'h00;
    wdata_out = 8'h00;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    stop_out  = 1'b0;
    abort_out = 1'b0;
  end

  // Address and data are inverted once a strobe drops, so nothing may lean on stale values.
  task automatic strobe(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= w;
    rd_out    <= ~w;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    rd_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    strobe(a, d, 1'b1);
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    strobe(a, 8'h00, 1'b0);
    #1 d = rdata_in;
  endtask

  // Ends the current transfer with a stop, or cuts it short when abort is set.
  task automatic frame(input logic abort);
    @(posedge clk_in);
    stop_out  <= ~abort;
    abort_out <= abort;
    @(posedge clk_in);
    stop_out  <= 1'b0;
    abort_out <= 1'b0;
    // Let the edge that takes the stop settle before anyone looks at the outputs.
    #1;
  endtask

  // Each arming step is a transfer of its own; the latches allow one update afterwards.
  task automatic unlock();
    wr(8'h3F, 8'h02);
    frame(1'b0);
    wr(8'h3F, 8'h06);
    frame(1'b0);
  endtask
endmodule

// *** rtcal_ccr_ctrl_tb.sv ***
// Self-checking bench for the clock/control block.
`timescale 1ns/1ps
module rtcal_ccr_ctrl_tb;
  `define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch at %0t got %h expected %h", $time, got, exp); end end
  logic       core_clk_in;
  logic       resetn_in;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata_out;
  logic       xfer_stop;
  logic       xfer_abort;
  logic       cmp_below_bat_in;
  logic       cmp_above_bat_in;
  logic       cmp_below_trip_in;
  logic       cmp_above_trip_in;
  logic       on_battery_out;
  logic       bus_enabled_out;
  logic       alarm_irq_out;
  logic       nv_busy_out;
  int         errors;
  int         compares;
  int         irqs;
  int         n;

  rtcal_ccr_ctrl #(.NV_WRITE_CYCLES(20)) DUT (
    .core_clk_in       (core_clk_in),
    .resetn_in         (resetn_in),
    .reg_addr_in       (reg_addr),
    .reg_wdata_in      (reg_wdata),
    .reg_wr_in         (reg_wr),
    .reg_rd_in         (reg_rd),
    .reg_rdata_out     (reg_rdata_out),
    .xfer_stop_in      (xfer_stop),
    .xfer_abort_in     (xfer_abort),
    .cmp_below_bat_in  (cmp_below_bat_in),
    .cmp_above_bat_in  (cmp_above_bat_in),
    .cmp_below_trip_in (cmp_below_trip_in),
    .cmp_above_trip_in (cmp_above_trip_in),
    .on_battery_out    (on_battery_out),
    .bus_enabled_out   (bus_enabled_out),
    .alarm_irq_out     (alarm_irq_out),
    .nv_busy_out       (nv_busy_out)
  );

  rtcal_host_model host (
    .clk_in    (core_clk_in),
    .rdata_in  (reg_rdata_out),
    .addr_out  (reg_addr),
    .wdata_out (reg_wdata),
    .wr_out    (reg_wr),
    .rd_out    (reg_rd),
    .stop_out  (xfer_stop),
    .abort_out (xfer_abort)
  );

  initial core_clk_in = 1'b0;
  always #10 core_clk_in = ~core_clk_in;

  always @(posedge core_clk_in)
    if (alarm_irq_out === 1'b1)
      irqs++;

  task automatic test_done();
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Programming takes a fixed count, so a longer wait means the block hung.
  task automatic wait_idle();
    int k;
    k = 0;
    while (nv_busy_out !== 1'b0 && k < 100)
    begin
      @(posedge core_clk_in);
      #1 k++;
    end
    if (k >= 100)
    begin
      errors++;
      test_done();
    end
  endtask

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    host.unlock();
    host.wr(a, d);
    host.frame(1'b0);
    wait_idle();
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    `CHK(d, e)
  endtask

  task automatic match();
    put(8'h30, 8'h00);
    put(8'h30, 8'h12);
  endtask

  // Comparator levels as one vector: above trip, below trip, above battery, below battery.
  task automatic set_cmp(input logic [3:0] v);
    {cmp_above_trip_in, cmp_below_trip_in, cmp_above_bat_in, cmp_below_bat_in} <= v;
  endtask

  // Comparators pass a two-flop synchroniser, so allow a few cycles to land.
  task automatic settle();
    repeat (5) @(posedge core_clk_in);
    #1;
  endtask

  initial
  begin
    errors = 0;
    compares = 0;
    irqs = 0;
    resetn_in = 1'b0;
    set_cmp(4'h0);
    repeat (4) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    #1;
    `CHK(bus_enabled_out, 1'b1)
    chk_rd(8'h3F, 8'h00);
    chk_rd(8'h14, 8'h40);
    host.wr(8'h30, 8'h55);
    host.frame(1'b0);
    chk_rd(8'h30, 8'h00);
    host.wr(8'h3F, 8'h02);
    host.frame(1'b0);
    chk_rd(8'h3F, 8'h02);
    host.wr(8'h3F, 8'h06);
    host.frame(1'b0);
    chk_rd(8'h3F, 8'h06);
    host.wr(8'h30, 8'h5A);
    host.frame(1'b0);
    `CHK(nv_busy_out, 1'b0)
    chk_rd(8'h3F, 8'h02);
    chk_rd(8'h30, 8'h5A);
    host.wr(8'h3F, 8'h00);
    host.frame(1'b0);
    chk_rd(8'h3F, 8'h00);
    host.unlock();
    host.wr(8'h12, 8'h11);
    host.frame(1'b1);
    chk_rd(8'h3F, 8'h06);
    host.wr(8'h12, 8'h22);
    host.frame(1'b0);
    `CHK(nv_busy_out, 1'b1)
    chk_rd(8'h3F, 8'h02);
    wait_idle();
    chk_rd(8'h12, 8'h22);
    // Only the low five bytes of each alarm close a committing write.
    for (int a = 0; a < 16; a++)
    begin
      host.unlock();
      host.wr(a[7:0], 8'h00);
      host.frame(1'b0);
      `CHK(nv_busy_out, a[2:0] <= 3'h4)
      wait_idle();
    end
    chk_rd(8'h05, 8'h00);
    host.unlock();
    for (int a = 6; a < 9; a++)
      host.wr(a[7:0], 8'h00);
    host.frame(1'b0);
    `CHK(nv_busy_out, 1'b1)
    wait_idle();
    host.unlock();
    for (int a = 9; a < 25; a++)
      host.wr({4'h0, a[3:0]}, 8'h00);
    host.frame(1'b0);
    `CHK(nv_busy_out, 1'b1)
    wait_idle();
    put(8'h00, 8'h92);
    put(8'h11, 8'h20);
    n = irqs;
    put(8'h30, 8'h12);
    chk_rd(8'h3F, 8'h22);
    `CHK(irqs, n + 1)
    chk_rd(8'h3F, 8'h02);
    put(8'h08, 8'h92);
    put(8'h11, 8'h60);
    match();
    chk_rd(8'h3F, 8'h62);
    put(8'h11, 8'hE0);
    n = irqs;
    match();
    chk_rd(8'h3F, 8'h22);
    match();
    `CHK(irqs, n + 2)
    chk_rd(8'h3F, 8'h22);
    put(8'h11, 8'hC0);
    match();
    chk_rd(8'h3F, 8'h42);
    put(8'h11, 8'hE1);
    match();
    chk_rd(8'h3F, 8'h02);
    @(posedge core_clk_in);
    set_cmp(4'h1);
    settle();
    `CHK(on_battery_out, 1'b1)
    `CHK(bus_enabled_out, 1'b1)
    chk_rd(8'h3F, 8'h82);
    set_cmp(4'h2);
    settle();
    `CHK(on_battery_out, 1'b0)
    set_cmp(4'h0);
    put(8'h14, 8'h80);
    set_cmp(4'h1);
    settle();
    `CHK(on_battery_out, 1'b0)
    set_cmp(4'h5);
    settle();
    `CHK(on_battery_out, 1'b1)
    `CHK(bus_enabled_out, 1'b0)
    chk_rd(8'h3F, 8'h00);
    set_cmp(4'h8);
    settle();
    `CHK(on_battery_out, 1'b0)
    `CHK(bus_enabled_out, 1'b1)
    test_done();
  end

  initial
  begin
    #1ms;
    errors++;
    test_done();
  end
endmodule
